// ### cxe_defs.vh
// constants shared by the miscellaneous instruction executor
`ifndef CXE_DEFS_VH
`define CXE_DEFS_VH
// register offsets on the plain register port
`define CXE_OFS_CMD 8'h00
`define CXE_OFS_OPERAND 8'h01
`define CXE_OFS_ZPTR 8'h02
`define CXE_OFS_SPTR 8'h03
`define CXE_OFS_STATUS 8'h04
`define CXE_OFS_RESULT 8'h05
`define CXE_OFS_STATE 8'h06
// command register fields
`define CXE_CMD_OP_LSB 0
`define CXE_CMD_OP_MSB 4
`define CXE_CMD_BIT_LSB 5
`define CXE_CMD_BIT_MSB 7
`define CXE_CMD_IO_LSB 8
`define CXE_CMD_IO_MSB 13
// reset values
`define CXE_RST_SPTR 16'h0FFF
`define CXE_RST_ZPTR 16'h0000
`define CXE_RST_STATUS 8'h00
// operation codes
`define CXE_OP_IN 5'h00
`define CXE_OP_OUT 5'h01
`define CXE_OP_PUSH 5'h02
`define CXE_OP_POP 5'h03
`define CXE_OP_XCH 5'h04
`define CXE_OP_LDSET 5'h05
`define CXE_OP_LDCLR 5'h06
`define CXE_OP_LDTGL 5'h07
`define CXE_OP_SHL 5'h08
`define CXE_OP_SHR 5'h09
`define CXE_OP_RLC 5'h0A
`define CXE_OP_RRC 5'h0B
`define CXE_OP_SAR 5'h0C
`define CXE_OP_SWAP 5'h0D
`define CXE_OP_FSET 5'h0E
`define CXE_OP_FCLR 5'h0F
`define CXE_OP_IOSET 5'h10
`define CXE_OP_IOCLR 5'h11
`define CXE_OP_TSTORE 5'h12
`define CXE_OP_TLOAD 5'h13
`define CXE_OP_BREAK 5'h14
`define CXE_OP_NOP 5'h15
`define CXE_OP_SLEEP 5'h16
`define CXE_OP_WDOG 5'h17
// status register bit positions
`define CXE_FLAG_C 0
`define CXE_FLAG_Z 1
`define CXE_FLAG_N 2
`define CXE_FLAG_V 3
`define CXE_FLAG_S 4
`define CXE_FLAG_H 5
`define CXE_FLAG_T 6
`define CXE_FLAG_I 7
`endif

// ### cxe_shift_unit.v
// shift, rotate and nibble swap datapath with its flag results
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_shift_unit (
   // operation and operand
   input wire [4:0] op_in,
   input wire [7:0] val_in,
   input wire [7:0] status_in,
   // result and updated status register
   output reg [7:0] res_out,
   output reg [7:0] status_out
);
   reg cin;
   reg cout;
   always @* begin
      cin = status_in[`CXE_FLAG_C];
      cout = 1'b0;
      res_out = val_in;
      status_out = status_in;
      case (op_in)
         `CXE_OP_SHL: begin
            res_out = {val_in[6:0], 1'b0};
            cout = val_in[7];
         end
         `CXE_OP_SHR: begin
            res_out = {1'b0, val_in[7:1]};
            cout = val_in[0];
         end
         `CXE_OP_RLC: begin
            res_out = {val_in[6:0], cin};
            cout = val_in[7];
         end
         `CXE_OP_RRC: begin
            res_out = {cin, val_in[7:1]};
            cout = val_in[0];
         end
         `CXE_OP_SAR: begin
            res_out = {val_in[7], val_in[7:1]};
            cout = val_in[0];
         end
         `CXE_OP_SWAP: begin
            res_out = {val_in[3:0], val_in[7:4]};
         end
         default: begin
            res_out = val_in;
         end
      endcase
      if (op_in >= `CXE_OP_SHL && op_in <= `CXE_OP_SAR) begin
         status_out[`CXE_FLAG_C] = cout;
         status_out[`CXE_FLAG_Z] = (res_out == 8'h00);
         status_out[`CXE_FLAG_N] = res_out[7];
         status_out[`CXE_FLAG_V] = res_out[7] ^ cout;
      end
      // left moves also report bit 3 as half carry
      if (op_in == `CXE_OP_SHL || op_in == `CXE_OP_RLC) begin
         status_out[`CXE_FLAG_H] = val_in[3];
      end
   end
endmodule // cxe_shift_unit
`default_nettype wire

// ### cxe_flag_unit.v
// status flag writes and transfers between register bits and the t flag
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_flag_unit (
   // operation, bit select and operand
   input wire [4:0] op_in,
   input wire [2:0] bit_in,
   input wire [7:0] val_in,
   input wire [7:0] status_in,
   // updated register value and status register
   output reg [7:0] res_out,
   output reg [7:0] status_out
);
   function [7:0] one_hot;
      input [2:0] idx;
      begin
         one_hot = 8'h01 << idx;
      end
   endfunction
   always @* begin
      res_out = val_in;
      status_out = status_in;
      case (op_in)
         `CXE_OP_FSET: status_out = status_in | one_hot(bit_in);
         `CXE_OP_FCLR: status_out = status_in & ~one_hot(bit_in);
         `CXE_OP_TSTORE: status_out[`CXE_FLAG_T] = val_in[bit_in];
         `CXE_OP_TLOAD: begin
            if (status_in[`CXE_FLAG_T]) begin
               res_out = val_in | one_hot(bit_in);
            end else begin
               res_out = val_in & ~one_hot(bit_in);
            end
         end
         default: res_out = val_in;
      endcase
   end
endmodule // cxe_flag_unit
`default_nettype wire

// ### cxe_misc_exec.v
// executor for i/o, stack, ram exchange, shift, bit and flag instructions
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_misc_exec #(
   parameter [15:0] SRAM_BASE = 16'h2000,
   parameter [1:0] SRAM_EXTRA = 2'h1
) (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // register port
   input wire [7:0] reg_addr_in,
   input wire [15:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output reg [15:0] reg_rdata_out,
   // data memory
   output reg [15:0] mem_addr_out,
   output reg [7:0] mem_wdata_out,
   output reg mem_we_out,
   output reg mem_re_out,
   input wire [7:0] mem_rdata_in,
   // i/o register space
   output reg [5:0] io_addr_out,
   output reg [7:0] io_wdata_out,
   output reg [7:0] io_wmask_out,
   output reg io_we_out,
   output reg io_re_out,
   input wire [7:0] io_rdata_in,
   // core control events
   output reg break_out,
   output reg sleep_out,
   output reg watchdog_restart_out,
   output wire busy_out
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_FIRST = 2'h1;
   localparam [1:0] ST_HOLD = 2'h2;
   localparam [1:0] ST_SECOND = 2'h3;

   reg [1:0] state;
   reg [4:0] op;
   reg [2:0] bit_sel;
   reg [7:0] operand;
   reg [15:0] zptr;
   reg [15:0] sptr;
   reg [7:0] status_register;
   reg [7:0] result;
   reg [1:0] hold_left;
   reg [7:0] cycles;
   reg [7:0] last_cycles;

   wire [7:0] sh_res;
   wire [7:0] sh_status;
   wire [7:0] fl_res;
   wire [7:0] fl_status;
   wire cmd_wr;
   wire [4:0] cmd_op;
   wire [2:0] cmd_bit;
   wire [5:0] cmd_io;
   wire [15:0] pop_addr;

   function [7:0] bit_mask;
      input [2:0] idx;
      begin
         bit_mask = 8'h01 << idx;
      end
   endfunction

   function is_zop;
      input [4:0] code;
      begin
         is_zop = (code >= `CXE_OP_XCH) && (code <= `CXE_OP_LDTGL);
      end
   endfunction

   // addresses at or above the sram base pay the extra access cycle
   function in_sram;
      input [15:0] addr;
      begin
         in_sram = (addr >= SRAM_BASE);
      end
   endfunction

   assign cmd_wr = reg_wr_in && (reg_addr_in == `CXE_OFS_CMD);
   assign cmd_op = reg_wdata_in[`CXE_CMD_OP_MSB:`CXE_CMD_OP_LSB];
   assign cmd_bit = reg_wdata_in[`CXE_CMD_BIT_MSB:`CXE_CMD_BIT_LSB];
   assign cmd_io = reg_wdata_in[`CXE_CMD_IO_MSB:`CXE_CMD_IO_LSB];
   assign pop_addr = sptr + 16'h0001;
   assign busy_out = (state != ST_IDLE);

   cxe_shift_unit u_shift (
      .op_in(op),
      .val_in(operand),
      .status_in(status_register),
      .res_out(sh_res),
      .status_out(sh_status)
   );

   cxe_flag_unit u_flag (
      .op_in(op),
      .bit_in(bit_sel),
      .val_in(operand),
      .status_in(status_register),
      .res_out(fl_res),
      .status_out(fl_status)
   );

   // register reads answer in the following cycle only
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 16'h0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `CXE_OFS_OPERAND: reg_rdata_out <= {8'h00, operand};
            `CXE_OFS_ZPTR: reg_rdata_out <= zptr;
            `CXE_OFS_SPTR: reg_rdata_out <= sptr;
            `CXE_OFS_STATUS: reg_rdata_out <= {8'h00, status_register};
            `CXE_OFS_RESULT: reg_rdata_out <= {8'h00, result};
            `CXE_OFS_STATE: reg_rdata_out <= {last_cycles, 5'h00, state, busy_out};
            default: reg_rdata_out <= 16'h0000;
         endcase
      end else begin
         reg_rdata_out <= 16'h0000;
      end
   end

   // software writes to plain registers; execution updates win on clash
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         state <= ST_IDLE;
         op <= `CXE_OP_NOP;
         bit_sel <= 3'h0;
         operand <= 8'h00;
         zptr <= `CXE_RST_ZPTR;
         sptr <= `CXE_RST_SPTR;
         status_register <= `CXE_RST_STATUS;
         result <= 8'h00;
         hold_left <= 2'h0;
         cycles <= 8'h00;
         last_cycles <= 8'h00;
         mem_addr_out <= 16'h0000;
         mem_wdata_out <= 8'h00;
         mem_we_out <= 1'b0;
         mem_re_out <= 1'b0;
         io_addr_out <= 6'h00;
         io_wdata_out <= 8'h00;
         io_wmask_out <= 8'h00;
         io_we_out <= 1'b0;
         io_re_out <= 1'b0;
         break_out <= 1'b0;
         sleep_out <= 1'b0;
         watchdog_restart_out <= 1'b0;
      end else begin
         mem_we_out <= 1'b0;
         mem_re_out <= 1'b0;
         io_we_out <= 1'b0;
         io_re_out <= 1'b0;
         break_out <= 1'b0;
         sleep_out <= 1'b0;
         watchdog_restart_out <= 1'b0;
         if (reg_wr_in && reg_addr_in == `CXE_OFS_OPERAND) begin
            operand <= reg_wdata_in[7:0];
         end
         if (reg_wr_in && reg_addr_in == `CXE_OFS_ZPTR) begin
            zptr <= reg_wdata_in;
         end
         if (reg_wr_in && reg_addr_in == `CXE_OFS_SPTR && state == ST_IDLE) begin
            sptr <= reg_wdata_in;
         end
         if (reg_wr_in && reg_addr_in == `CXE_OFS_STATUS && state == ST_IDLE) begin
            status_register <= reg_wdata_in[7:0];
         end
         if (state != ST_IDLE) begin
            cycles <= cycles + 8'h01;
         end
         case (state)
            ST_IDLE: begin
               // a command is taken only while idle; it launches cycle one
               if (cmd_wr) begin
                  op <= cmd_op;
                  bit_sel <= cmd_bit;
                  cycles <= 8'h00;
                  state <= ST_FIRST;
                  io_addr_out <= cmd_io;
                  case (cmd_op)
                     `CXE_OP_IN: io_re_out <= 1'b1;
                     `CXE_OP_OUT: begin
                        io_we_out <= 1'b1;
                        io_wdata_out <= operand;
                        io_wmask_out <= 8'hFF;
                     end
                     `CXE_OP_IOSET: begin
                        io_we_out <= 1'b1;
                        io_wdata_out <= 8'hFF;
                        io_wmask_out <= bit_mask(cmd_bit);
                     end
                     `CXE_OP_IOCLR: begin
                        io_we_out <= 1'b1;
                        io_wdata_out <= 8'h00;
                        io_wmask_out <= bit_mask(cmd_bit);
                     end
                     `CXE_OP_PUSH: begin
                        mem_addr_out <= sptr;
                        mem_wdata_out <= operand;
                        if (in_sram(sptr) && SRAM_EXTRA != 2'h0) begin
                           hold_left <= SRAM_EXTRA;
                           state <= ST_HOLD;
                        end else begin
                           mem_we_out <= 1'b1;
                        end
                     end
                     `CXE_OP_BREAK: break_out <= 1'b1;
                     `CXE_OP_SLEEP: sleep_out <= 1'b1;
                     `CXE_OP_WDOG: watchdog_restart_out <= 1'b1;
                     default: begin
                        if (is_zop(cmd_op)) begin
                           mem_addr_out <= zptr;
                           mem_re_out <= 1'b1;
                        end
                     end
                  endcase
               end
            end
            ST_FIRST: begin
               state <= ST_IDLE;
               case (op)
                  `CXE_OP_IN: result <= io_rdata_in;
                  `CXE_OP_PUSH: sptr <= sptr - 16'h0001;
                  `CXE_OP_POP: begin
                     sptr <= pop_addr;
                     mem_addr_out <= pop_addr;
                     if (in_sram(pop_addr) && SRAM_EXTRA != 2'h0) begin
                        hold_left <= SRAM_EXTRA;
                        state <= ST_HOLD;
                     end else begin
                        mem_re_out <= 1'b1;
                        state <= ST_SECOND;
                     end
                  end
                  `CXE_OP_SHL, `CXE_OP_SHR, `CXE_OP_RLC, `CXE_OP_RRC, `CXE_OP_SAR,
                  `CXE_OP_SWAP: begin
                     result <= sh_res;
                     status_register <= sh_status;
                  end
                  `CXE_OP_FSET, `CXE_OP_FCLR, `CXE_OP_TSTORE: begin
                     status_register <= fl_status;
                  end
                  `CXE_OP_TLOAD: result <= fl_res;
                  default: begin
                     if (is_zop(op)) begin
                        // old byte goes back to the register side
                        result <= mem_rdata_in;
                        case (op)
                           `CXE_OP_LDSET: mem_wdata_out <= operand | mem_rdata_in;
                           `CXE_OP_LDCLR: mem_wdata_out <= ~operand & mem_rdata_in;
                           `CXE_OP_LDTGL: mem_wdata_out <= operand ^ mem_rdata_in;
                           default: mem_wdata_out <= operand;
                        endcase
                        if (in_sram(zptr) && SRAM_EXTRA != 2'h0) begin
                           hold_left <= SRAM_EXTRA;
                           state <= ST_HOLD;
                        end else begin
                           mem_we_out <= 1'b1;
                           state <= ST_SECOND;
                        end
                     end
                  end
               endcase
               if (state == ST_FIRST && !(op == `CXE_OP_POP || is_zop(op))) begin
                  last_cycles <= 8'h01;
               end
            end
            ST_HOLD: begin
               // address stays put while the internal sram catches up
               hold_left <= hold_left - 2'h1;
               if (hold_left == 2'h1) begin
                  state <= ST_SECOND;
                  mem_re_out <= (op == `CXE_OP_POP);
                  mem_we_out <= is_zop(op) || op == `CXE_OP_PUSH;
               end
            end
            ST_SECOND: begin
               // memory timing here assumes the on-chip memory, no wait signal
               if (op == `CXE_OP_POP) begin
                  result <= mem_rdata_in;
               end
               if (op == `CXE_OP_PUSH) begin
                  sptr <= sptr - 16'h0001;
               end
               last_cycles <= cycles + 8'h01;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule // cxe_misc_exec
`default_nettype wire

// ### cxe_misc_exec_assertions.sv
// port assertions for the miscellaneous instruction executor
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module cxe_misc_exec_assertions (
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_rdata_out,
   // memory, i/o and events
   input wire logic [15:0] mem_addr_out,
   input wire logic mem_we_out,
   input wire logic mem_re_out,
   input wire logic [5:0] io_addr_out,
   input wire logic [7:0] io_wdata_out,
   input wire logic [7:0] io_wmask_out,
   input wire logic io_we_out,
   input wire logic io_re_out,
   input wire logic break_out,
   input wire logic sleep_out,
   input wire logic watchdog_restart_out,
   input wire logic busy_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   wire logic go = reg_wr_in && reg_addr_in == `CXE_OFS_CMD && !busy_out;
   logic [4:0] p_op;
   logic [2:0] p_bit;
   logic [5:0] p_io;
   logic p_go;
   // command fields as taken one edge earlier
   always @(posedge core_clk_in) begin
      p_op <= reg_wdata_in[4:0];
      p_bit <= reg_wdata_in[7:5];
      p_io <= reg_wdata_in[13:8];
      p_go <= go;
   end
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
      else $error("read data not zero outside the read cycle");
   a_cmd_starts: assert property (go |=> busy_out)
      else $error("accepted command did not start");
   a_short_ops: assert property (go && reg_wdata_in[4:0] inside {[5'h08:5'h17]}
      |=> busy_out && !mem_re_out && !mem_we_out ##1 !busy_out)
      else $error("single cycle op took longer or touched memory");
   a_busy_bound: assert property ($rose(busy_out) |-> ##[1:3] !busy_out)
      else $error("operation ran too long");
   a_mem_write_last: assert property (mem_we_out |-> busy_out ##1 !busy_out)
      else $error("memory write not in last busy cycle");
   a_zop_write: assert property ($rose(busy_out) && mem_re_out
      |-> ##[1:2] (mem_we_out && $stable(mem_addr_out)))
      else $error("read-modify-write did not write back to same address");
   a_pop_read_last: assert property (mem_re_out && !$rose(busy_out) |-> busy_out ##1 !busy_out)
      else $error("stack read not in last busy cycle");
   a_io_one_cycle: assert property (io_we_out || io_re_out |-> busy_out && p_go ##1 !busy_out)
      else $error("i/o access not a one cycle op");
   a_io_target: assert property (io_we_out |-> io_addr_out == p_io &&
      io_wmask_out == (p_op == `CXE_OP_OUT ? 8'hFF : 8'h01 << p_bit))
      else $error("i/o write address or mask wrong");
   a_io_bit_value: assert property (io_we_out && p_op != `CXE_OP_OUT
      |-> io_wdata_out == (p_op == `CXE_OP_IOSET ? 8'hFF : 8'h00))
      else $error("i/o bit write value wrong");
   a_event_cause: assert property (break_out || sleep_out || watchdog_restart_out
      |-> p_go && {break_out, sleep_out, watchdog_restart_out} ==
      {p_op == `CXE_OP_BREAK, p_op == `CXE_OP_SLEEP, p_op == 5'h17})
      else $error("core event pulse without matching command");
   c_pop_extra: cover property (go && reg_wdata_in[4:0] == `CXE_OP_POP ##1 busy_out [*3]);
   c_refused: cover property (reg_wr_in && reg_addr_in == `CXE_OFS_CMD && busy_out);
   c_io_bit: cover property (io_we_out && io_wmask_out != 8'hFF);
   c_event: cover property (watchdog_restart_out);
endmodule // cxe_misc_exec_assertions
bind cxe_misc_exec cxe_misc_exec_assertions chk (.core_clk_in, .rstn_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_addr_out, .mem_we_out,
   .mem_re_out, .io_addr_out, .io_wdata_out, .io_wmask_out, .io_we_out, .io_re_out,
   .break_out, .sleep_out, .watchdog_restart_out, .busy_out);
`default_nettype wire

// ### cxe_far_model.sv
// behavioural data memory and i/o register space facing the executor
`timescale 1ns/1ps
`default_nettype none
module cxe_far_model (
   // clock
   input wire logic core_clk_in,
   // data memory
   input wire logic [15:0] mem_addr_in,
   input wire logic [7:0] mem_wdata_in,
   input wire logic mem_we_in,
   input wire logic mem_re_in,
   output logic [7:0] mem_rdata_out,
   // i/o register space
   input wire logic [5:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic [7:0] io_wmask_in,
   input wire logic io_we_in,
   input wire logic io_re_in,
   output logic [7:0] io_rdata_out
);
   logic [7:0] mem [0:65535];
   logic [7:0] io_mem [0:63];
   logic [7:0] last_mem = 8'h00;
   logic [7:0] last_io = 8'h00;
   initial begin
      for (int j = 0; j < 65536; j++) mem[j] = j[7:0] ^ j[15:8] ^ 8'h5A;
      for (int j = 0; j < 64; j++) io_mem[j] = j[7:0] ^ 8'hC3;
   end
   // zero-wait internal memory; idle lines show the inverse of the last byte
   assign mem_rdata_out = mem_re_in ? mem[mem_addr_in] : ~last_mem;
   assign io_rdata_out = io_re_in ? io_mem[io_addr_in] : ~last_io;
   always @(posedge core_clk_in) begin
      if (mem_re_in) last_mem <= mem[mem_addr_in];
      if (io_re_in) last_io <= io_mem[io_addr_in];
      if (mem_we_in) mem[mem_addr_in] <= mem_wdata_in;
      if (io_we_in) io_mem[io_addr_in] <= (io_mem[io_addr_in] & ~io_wmask_in) |
         (io_wdata_in & io_wmask_in);
   end
endmodule // cxe_far_model
`default_nettype wire

// ### core_misc_instruction_exec_tb.sv
// self-checking testbench for the miscellaneous instruction executor
`timescale 1ns/1ps
`default_nettype none
`include "cxe_defs.vh"
module core_misc_instruction_exec_tb;
   localparam logic [15:0] SB = 16'h2000;
   logic core_clk_in, rstn_in, reg_wr_in, reg_rd_in;
   logic [7:0] reg_addr_in;
   logic [15:0] reg_wdata_in;
   wire logic [15:0] reg_rdata_out, mem_addr_out;
   wire logic [7:0] mem_wdata_out, mem_rdata_in, io_wdata_out, io_wmask_out, io_rdata_in;
   wire logic [5:0] io_addr_out;
   wire logic mem_we_out, mem_re_out, io_we_out, io_re_out;
   wire logic break_out, sleep_out, watchdog_restart_out, busy_out;
   integer n_errors = 0;
   integer n_compared = 0;
   integer i, cyc, ec;
   logic [31:0] seed = 32'hD5CA29C0;
   logic [15:0] v, sp, z;
   logic [7:0] opd, st, old, er, es, mk;
   logic [4:0] op;
   logic [2:0] b;
   logic [5:0] a;
   cxe_misc_exec #(.SRAM_BASE(SB), .SRAM_EXTRA(2'h1)) dut (.core_clk_in, .rstn_in, .reg_addr_in,
      .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .mem_addr_out, .mem_wdata_out,
      .mem_we_out, .mem_re_out, .mem_rdata_in, .io_addr_out, .io_wdata_out, .io_wmask_out,
      .io_we_out, .io_re_out, .io_rdata_in, .break_out, .sleep_out, .watchdog_restart_out,
      .busy_out);
   cxe_far_model mdl (.core_clk_in, .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_we_in(mem_we_out), .mem_re_in(mem_re_out), .mem_rdata_out(mem_rdata_in),
      .io_addr_in(io_addr_out), .io_wdata_in(io_wdata_out), .io_wmask_in(io_wmask_out),
      .io_we_in(io_we_out), .io_re_in(io_re_out), .io_rdata_out(io_rdata_in));
   initial begin
      core_clk_in = 1'b0;
      forever #50 core_clk_in = ~core_clk_in;
   end
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected result byte and status; m is the old memory or i/o byte
   function logic [15:0] model(input logic [4:0] o, input logic [2:0] bt, input logic [7:0] x,
      input logic [7:0] s, input logic [7:0] m);
      logic [7:0] r;
      logic c;
      r = x;
      c = s[0];
      case (o)
         5'h00, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07: r = m;
         5'h08: {c, r} = {x, 1'b0};
         5'h09: {r, c} = {1'b0, x};
         5'h0A: {c, r} = {x, s[0]};
         5'h0B: {r, c} = {s[0], x};
         5'h0C: {r, c} = {x[7], x};
         5'h0D: r = {x[3:0], x[7:4]};
         5'h0E: s[bt] = 1'b1;
         5'h0F: s[bt] = 1'b0;
         5'h12: s[6] = x[bt];
         5'h13: r[bt] = s[6];
         default: ;
      endcase
      if (o >= 5'h08 && o <= 5'h0C) s[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
      return {r, s};
   endfunction
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: op %h got %h exp %h", $time, op, got, exp);
      end
   endtask
   task chk8(input logic [7:0] got, input logic [7:0] exp);
      chk({8'h00, got}, {8'h00, exp});
   endtask
   task reg_write(input logic [7:0] ad, input logic [15:0] d);
      @(posedge core_clk_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
   endtask
   task reg_read(input logic [7:0] ad);
      @(posedge core_clk_in);
      reg_addr_in <= ad;
      reg_rd_in <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in <= 1'b0;
      #1 v = reg_rdata_out;
   endtask
   task rd_chk(input logic [7:0] ad, input logic [15:0] e);
      reg_read(ad);
      chk(v, e);
   endtask
   // issue a command and count the cycles that busy stays high
   task run(input logic [15:0] cmd);
      reg_write(`CXE_OFS_CMD, cmd);
      #1 cyc = 0;
      while (busy_out === 1'b1 && cyc < 8) begin
         @(posedge core_clk_in);
         #1 cyc++;
      end
   endtask
   task final_report;
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #2000000;
      n_errors++;
      $display("watchdog expired");
      final_report;
   end
   initial begin
      rstn_in = 1'b0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      reg_addr_in = 8'h00;
      reg_wdata_in = 16'h0000;
      repeat (20) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      rd_chk(`CXE_OFS_SPTR, `CXE_RST_SPTR);
      rd_chk(`CXE_OFS_ZPTR, `CXE_RST_ZPTR);
      rd_chk(`CXE_OFS_STATUS, {8'h00, `CXE_RST_STATUS});
      reg_write(8'h07, 16'hFFFF);
      rd_chk(8'h07, 16'h0000);
      $display("test reset and map done");
      for (i = 0; i < 256; i++) begin
         op = i[4:0];
         if (op > 5'h17) continue;
         seed = lfsr(seed);
         opd = seed[7:0];
         st = seed[15:8];
         b = (op == 5'h0E || op == 5'h0F) ? i[7:5] : seed[18:16];
         a = seed[24:19];
         z = {seed[25] ? 8'h20 : 8'h1F, seed[31:24]};
         sp = {seed[26] ? 8'h20 : 8'h1F, seed[23:16]};
         if (i == 3) sp = 16'h1FFF;
         if (i == 35) sp = 16'h1FFE;
         if (i == 5) z = 16'h1FFF;
         if (i == 37) z = 16'h2000;
         reg_write(`CXE_OFS_OPERAND, {8'h00, opd});
         reg_write(`CXE_OFS_ZPTR, z);
         reg_write(`CXE_OFS_SPTR, sp);
         reg_write(`CXE_OFS_STATUS, {8'h00, st});
         old = (op == 5'h00 || op == 5'h10 || op == 5'h11) ? mdl.io_mem[a] :
            (op == 5'h03) ? mdl.mem[sp + 16'h0001] : mdl.mem[z];
         {er, es} = model(op, b, opd, st, old);
         ec = (op == 5'h03) ? ((sp + 16'h0001 >= SB) ? 3 : 2) :
            (op >= 5'h04 && op <= 5'h07) ? ((z >= SB) ? 3 : 2) :
            (op == 5'h02 && sp >= SB) ? 2 : 1;
         run({2'b00, a, b, op});
         chk(cyc[15:0], ec[15:0]);
         if (op == 5'h00 || (op >= 5'h03 && op <= 5'h0D) || op == 5'h13)
            rd_chk(`CXE_OFS_RESULT, {8'h00, er});
         mk = (op == 5'h08 || op == 5'h0A) ? 8'hDF : 8'hFF;
         reg_read(`CXE_OFS_STATUS);
         chk(v & {8'h00, mk}, {8'h00, es & mk});
         rd_chk(`CXE_OFS_SPTR, op == 5'h02 ? sp - 16'h0001 : op == 5'h03 ? sp + 16'h0001 : sp);
         case (op)
            5'h01: chk8(mdl.io_mem[a], opd);
            5'h10: chk8(mdl.io_mem[a], old | (8'h01 << b));
            5'h11: chk8(mdl.io_mem[a], old & ~(8'h01 << b));
            5'h02: chk8(mdl.mem[sp], opd);
            5'h04: chk8(mdl.mem[z], opd);
            5'h05: chk8(mdl.mem[z], opd | old);
            5'h06: chk8(mdl.mem[z], ~opd & old);
            5'h07: chk8(mdl.mem[z], opd ^ old);
            default: ;
         endcase
      end
      $display("test random instructions done");
      reg_read(`CXE_OFS_RESULT);
      er = v[7:0];
      reg_write(`CXE_OFS_RESULT, ~v);
      rd_chk(`CXE_OFS_RESULT, {8'h00, er});
      reg_write(`CXE_OFS_SPTR, 16'h2004);
      reg_write(`CXE_OFS_STATUS, 16'h0000);
      reg_write(`CXE_OFS_CMD, {11'h000, `CXE_OP_POP});
      run({11'h000, `CXE_OP_FSET});
      rd_chk(`CXE_OFS_STATUS, 16'h0000);
      rd_chk(`CXE_OFS_SPTR, 16'h2005);
      $display("test refused command done");
      @(posedge core_clk_in);
      rstn_in <= 1'b0;
      repeat (2) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      rd_chk(`CXE_OFS_SPTR, `CXE_RST_SPTR);
      $display("test second reset done");
      final_report;
   end
endmodule // core_misc_instruction_exec_tb
`default_nettype wire
